/* File: verilog/teg_pkg.sv */
// constants for the timer event generator and channel mode block
// assumes a 16-bit register port with byte offsets as listed here
package teg_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_EVGEN = 8'h14;
  localparam logic [7:0] OFF_CHMODE = 8'h18;
  localparam logic [7:0] OFF_CCV1 = 8'h34;
  localparam logic [7:0] OFF_CCV_STEP = 8'h04;

  // reset values
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [15:0] RST_CHMODE = 16'h0000;
  localparam logic [15:0] RST_CCV = 16'h0000;

  // generation and status bit positions
  localparam int EG_UPD = 0;
  localparam int EG_CH1 = 1;
  localparam int EG_TRIG = 6;
  localparam int EG_W = 7;
  localparam logic [6:0] EG_MASK = 7'h5f;
  localparam int ST_OVR1 = 9;
  localparam logic [15:0] ST_MASK = 16'h1e5f;

  // channel mode field positions, channel two adds CH2_BASE
  localparam int CM_SEL = 0;
  localparam int CM_FAST = 2;
  localparam int CM_PRE = 3;
  localparam int CM_MODE = 4;
  localparam int CM_CLR = 7;
  localparam int CH2_BASE = 8;

  // direction select codes
  localparam logic [1:0] SEL_OUT = 2'b00;
  localparam logic [1:0] SEL_OWN = 2'b01;
  localparam logic [1:0] SEL_OTHER = 2'b10;
  localparam logic [1:0] SEL_TRC = 2'b11;

  // output compare modes
  typedef enum logic [2:0] {
    OCM_FROZEN = 3'b000,
    OCM_SET_HI = 3'b001,
    OCM_SET_LO = 3'b010,
    OCM_TOGGLE = 3'b011,
    OCM_FORCE_LO = 3'b100,
    OCM_FORCE_HI = 3'b101,
    OCM_PWM1 = 3'b110,
    OCM_PWM2 = 3'b111
  } teg_oc_mode_t;

endpackage

/* File: verilog/teg_oc_ref.sv */
// output reference generator for one compare channel
// assumes match and ordering flags computed by the caller each cycle
`timescale 1ns/1ps
`default_nettype none
module teg_oc_ref
  import teg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire teg_oc_mode_t i_mode,
  input wire logic i_is_output,
  input wire logic i_match,
  input wire logic i_below,
  input wire logic i_above,
  input wire logic i_down,
  input wire logic i_clear_on,
  input wire logic i_ext_clear,
  input wire logic i_pol,
  input wire logic i_npol,
  output logic o_ref,
  output logic o_main,
  output logic o_comp
);

  logic ref_q; // stored reference level

  // reference follows the selected compare mode
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ref_q <= 1'b0;
    end else if (!i_is_output) begin
      ref_q <= 1'b0; // input channel: no compare meaning
    end else begin
      case (i_mode)
        OCM_FROZEN: ref_q <= ref_q;
        OCM_SET_HI: if (i_match) ref_q <= 1'b1;
        OCM_SET_LO: if (i_match) ref_q <= 1'b0;
        OCM_TOGGLE: if (i_match) ref_q <= ~ref_q;
        OCM_FORCE_LO: ref_q <= 1'b0;
        OCM_FORCE_HI: ref_q <= 1'b1;
        OCM_PWM1: ref_q <= i_down ? ~i_above : i_below;
        OCM_PWM2: ref_q <= i_down ? i_above : ~i_below;
        default: ref_q <= 1'b0;
      endcase
    end
  end

  // clear acts without a clock edge so the reference drops at once
  assign o_ref = ref_q & ~(i_clear_on & i_ext_clear);
  // one reference, two outputs, each with its own active level
  assign o_main = o_ref ^ i_pol;
  assign o_comp = ~o_ref ^ i_npol;

endmodule // teg_oc_ref
`default_nettype wire

/* File: verilog/teg_event_gen.sv */
// timer software event generation, status flags, capture/compare
// values and the mode register for channels one and two
// assumes the counter core supplies count, reload, direction and ticks
`timescale 1ns/1ps
`default_nettype none
module teg_event_gen
  import teg_pkg::*;
#(
  parameter int CW = 16 // counter width
)
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic [CW-1:0] i_count_value,
  input wire logic [CW-1:0] i_auto_reload_value,
  input wire logic i_count_down,
  input wire logic i_count_tick,
  input wire logic i_update_hw,
  input wire logic i_trigger_hw,
  input wire logic [3:0] i_chan_on,
  input wire logic [1:0] i_chan34_input,
  input wire logic i_trigger_source_select_int,
  input wire logic i_pin_input_one,
  input wire logic i_pin_input_two,
  input wire logic i_pin_input_three,
  input wire logic i_pin_input_four,
  input wire logic i_internal_trigger_source,
  input wire logic i_external_trigger_filtered,
  input wire logic i_chan1_polarity,
  input wire logic i_chan1_complement_polarity,
  input wire logic i_chan2_polarity,
  input wire logic i_chan2_complement_polarity,
  input wire logic [6:0] i_int_en,
  input wire logic [6:0] i_dma_en,
  output logic o_update_event,
  output logic o_prescaler_clear,
  output logic o_count_load,
  output logic [CW-1:0] o_count_load_value,
  output logic o_trigger_event,
  output logic [3:0] o_chan_event,
  output logic o_irq,
  output logic [6:0] o_dma_req,
  output logic o_chan1_reference,
  output logic o_chan1_main_out,
  output logic o_chan1_complement_out,
  output logic o_chan2_reference,
  output logic o_chan2_main_out,
  output logic o_chan2_complement_out
);

  ////////////////////////////////////////////////////////////////////
  // decode and state
  ////////////////////////////////////////////////////////////////////

  logic [EG_W-1:0] evt_q; // generation bits, live one cycle
  logic [15:0] sts_q; // status flags
  logic [15:0] mode_q; // channel mode register
  logic [CW-1:0] ccv_act_q [4]; // active compare or captured value
  logic [CW-1:0] ccv_shd_q [4]; // preload copy
  logic [CW-1:0] load_val_q; // counter reload value
  logic [15:0] rdata_q; // read data
  logic [3:0] src_q; // previous capture source level
  logic eg_wr; // write to generation register
  logic st_wr; // write to status register
  logic cm_wr; // write to mode register
  logic [3:0] ccv_wr; // write to a value register
  logic [3:0] ccv_rd; // read of a value register
  logic [3:0] is_in; // channel configured as input
  logic [3:0] pre_on; // preload enabled per channel
  logic [3:0] src; // selected capture source
  logic [3:0] cap_ev; // capture event
  logic [3:0] cmp_ev; // compare event
  logic [3:0] hw_match; // counter equals active compare
  logic upd_ev; // any update event
  logic [1:0] sel1; // channel one select
  logic [1:0] sel2; // channel two select

  assign eg_wr = i_wr && (i_addr == OFF_EVGEN);
  assign st_wr = i_wr && (i_addr == OFF_STATUS);
  assign cm_wr = i_wr && (i_addr == OFF_CHMODE);
  assign sel1 = mode_q[CM_SEL+:2];
  assign sel2 = mode_q[CH2_BASE+CM_SEL+:2];

  // value register decode, one word per channel
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      ccv_wr[n] = i_wr && (i_addr == OFF_CCV1 + 8'(n) * OFF_CCV_STEP);
      ccv_rd[n] = i_rd && (i_addr == OFF_CCV1 + 8'(n) * OFF_CCV_STEP);
    end
  end

  // direction from the select fields, channels three and four from i_chan34_input; other bits change meaning
  assign is_in = {i_chan34_input, sel2 != SEL_OUT, sel1 != SEL_OUT};
  // preload only known for channels one and two here
  assign pre_on = {2'b00, mode_q[CH2_BASE+CM_PRE], mode_q[CM_PRE]};

  ////////////////////////////////////////////////////////////////////
  // input mapping and capture sources
  ////////////////////////////////////////////////////////////////////

  // channel one source; internal trigger only if selected upstream
  always_comb begin
    case (sel1)
      SEL_OWN: src[0] = i_pin_input_one;
      SEL_OTHER: src[0] = i_pin_input_two;
      SEL_TRC: src[0] = i_internal_trigger_source
                        && i_trigger_source_select_int;
      default: src[0] = 1'b0;
    endcase
  end

  // channel two source mirrors channel one
  always_comb begin
    case (sel2)
      SEL_OWN: src[1] = i_pin_input_two;
      SEL_OTHER: src[1] = i_pin_input_one;
      SEL_TRC: src[1] = i_internal_trigger_source
                        && i_trigger_source_select_int;
      default: src[1] = 1'b0;
    endcase
  end

  // channels three and four use their own pins
  assign src[2] = i_pin_input_three && i_chan34_input[0];
  assign src[3] = i_pin_input_four && i_chan34_input[1];

  // previous source level for rising edge capture
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      src_q <= 4'h0;
    end else begin
      src_q <= src;
    end
  end

  // events per channel; all bits act together in one cycle
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      hw_match[n] = i_count_tick && (i_count_value == ccv_act_q[n]);
      cap_ev[n] = is_in[n] && (evt_q[EG_CH1+n]
                               || (src[n] && !src_q[n]));
      cmp_ev[n] = !is_in[n] && (evt_q[EG_CH1+n] || hw_match[n]);
    end
  end
  assign upd_ev = evt_q[EG_UPD] || i_update_hw;

  ////////////////////////////////////////////////////////////////////
  // event generation register
  ////////////////////////////////////////////////////////////////////

  // reserved bits are masked, so stray ones do no harm
  // a written one lives exactly one cycle, then hardware clears it
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      evt_q <= '0;
    end else if (eg_wr) begin
      evt_q <= i_wdata[EG_W-1:0] & EG_MASK;
    end else begin
      evt_q <= '0;
    end
  end

  // reload value chosen at the write, from direction
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      load_val_q <= '0;
    end else if (eg_wr && i_wdata[EG_UPD]) begin
      load_val_q <= i_count_down ? i_auto_reload_value : '0;
    end
  end

  // update clears prescaler and loads counter in the same cycle
  assign o_update_event = evt_q[EG_UPD];
  assign o_prescaler_clear = evt_q[EG_UPD];
  assign o_count_load = evt_q[EG_UPD];
  assign o_count_load_value = load_val_q;
  assign o_trigger_event = evt_q[EG_TRIG];
  assign o_chan_event = evt_q[EG_CH1+:4];

  ////////////////////////////////////////////////////////////////////
  // status flags: software writes zero to clear, set wins
  ////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sts_q <= RST_STATUS;
    end else begin
      for (int b = 0; b < 16; b++) begin
        if (st_wr && !i_wdata[b]) begin
          sts_q[b] <= 1'b0;
        end
      end
      for (int n = 0; n < 4; n++) begin
        if (ccv_rd[n] && is_in[n]) begin
          sts_q[EG_CH1+n] <= 1'b0; // reading a capture clears it
        end
        if (cap_ev[n] || cmp_ev[n]) begin
          sts_q[EG_CH1+n] <= 1'b1;
        end
        if (cap_ev[n] && sts_q[EG_CH1+n]) begin
          sts_q[ST_OVR1+n] <= 1'b1;
        end
      end
      if (upd_ev) begin
        sts_q[EG_UPD] <= 1'b1;
      end
      if (evt_q[EG_TRIG] || i_trigger_hw) begin
        sts_q[EG_TRIG] <= 1'b1;
      end
    end
  end

  // interrupt from enabled flags, dma as a pulse per event
  assign o_irq = |(sts_q[6:0] & i_int_en & EG_MASK);
  assign o_dma_req = {evt_q[EG_TRIG] | i_trigger_hw, 1'b0,
                      cap_ev | cmp_ev, upd_ev} & i_dma_en;

  ////////////////////////////////////////////////////////////////////
  // channel mode register
  ////////////////////////////////////////////////////////////////////

  // select fields are locked while their channel is on
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      mode_q <= RST_CHMODE;
    end else if (cm_wr) begin
      mode_q[7:2] <= i_wdata[7:2];
      mode_q[15:10] <= i_wdata[15:10];
      if (!i_chan_on[0]) begin
        mode_q[CM_SEL+:2] <= i_wdata[CM_SEL+:2];
      end
      if (!i_chan_on[1]) begin
        mode_q[CH2_BASE+CM_SEL+:2] <= i_wdata[CH2_BASE+CM_SEL+:2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // capture/compare values
  ////////////////////////////////////////////////////////////////////

  // capture wins over software writes; preload goes through shadow
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      for (int n = 0; n < 4; n++) begin
        ccv_act_q[n] <= RST_CCV[CW-1:0];
        ccv_shd_q[n] <= RST_CCV[CW-1:0];
      end
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (cap_ev[n]) begin
          ccv_act_q[n] <= i_count_value;
        end else if (ccv_wr[n] && !is_in[n]) begin
          ccv_shd_q[n] <= i_wdata[CW-1:0];
          if (!pre_on[n]) begin
            ccv_act_q[n] <= i_wdata[CW-1:0];
          end
        end else if (upd_ev && pre_on[n] && !is_in[n]) begin
          ccv_act_q[n] <= ccv_shd_q[n];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe
  ////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rdata_q <= 16'h0000;
    end else if (i_rd) begin
      rdata_q <= 16'h0000; // generation and unmapped read zero
      if (i_addr == OFF_STATUS) begin
        rdata_q <= sts_q & ST_MASK;
      end
      if (i_addr == OFF_CHMODE) begin
        rdata_q <= mode_q;
      end
      for (int n = 0; n < 4; n++) begin
        if (ccv_rd[n]) begin
          rdata_q <= 16'(pre_on[n] ? ccv_shd_q[n] : ccv_act_q[n]);
        end
      end
      if (i_addr == OFF_EVGEN) begin
        rdata_q <= 16'h0000;
      end
    end
  end
  assign o_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////
  // output reference for channels one and two
  ////////////////////////////////////////////////////////////////////

  teg_oc_ref u_ref1 (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_mode(teg_oc_mode_t'(mode_q[CM_MODE+:3])),
    .i_is_output(!is_in[0]),
    .i_match(hw_match[0]),
    .i_below(i_count_value < ccv_act_q[0]),
    .i_above(i_count_value > ccv_act_q[0]),
    .i_down(i_count_down),
    .i_clear_on(mode_q[CM_CLR]),
    .i_ext_clear(i_external_trigger_filtered),
    .i_pol(i_chan1_polarity),
    .i_npol(i_chan1_complement_polarity),
    .o_ref(o_chan1_reference),
    .o_main(o_chan1_main_out),
    .o_comp(o_chan1_complement_out)
  );

  teg_oc_ref u_ref2 (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_mode(teg_oc_mode_t'(mode_q[CH2_BASE+CM_MODE+:3])),
    .i_is_output(!is_in[1]),
    .i_match(hw_match[1]),
    .i_below(i_count_value < ccv_act_q[1]),
    .i_above(i_count_value > ccv_act_q[1]),
    .i_down(i_count_down),
    .i_clear_on(mode_q[CH2_BASE+CM_CLR]),
    .i_ext_clear(i_external_trigger_filtered),
    .i_pol(i_chan2_polarity),
    .i_npol(i_chan2_complement_polarity),
    .o_ref(o_chan2_reference),
    .o_main(o_chan2_main_out),
    .o_comp(o_chan2_complement_out)
  );

  ////////////////////////////////////////////////////////////////////
  // checks
  ////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence trig_write_s;
    eg_wr && i_wdata[EG_TRIG];
  endsequence

  sequence trig_fire_s;
    o_trigger_event ##1 sts_q[EG_TRIG];
  endsequence

  trig_flag_a: assert property (trig_write_s |=> trig_fire_s)
    else $error("trigger write did not set trigger flag");
  evt_clear_a: assert property (!eg_wr |=> evt_q == '0)
    else $error("generation bit not cleared");
  match_flag_a: assert property (
    evt_q[EG_CH1] && !is_in[0] |=> sts_q[EG_CH1])
    else $error("output channel event did not set flag");
  cap_value_a: assert property (
    evt_q[EG_CH1] && is_in[0] |=> ccv_act_q[0] == $past(i_count_value)
                                  && sts_q[EG_CH1])
    else $error("software capture value wrong");
  overcap_set_a: assert property (
    cap_ev[0] && sts_q[EG_CH1] |=> sts_q[ST_OVR1])
    else $error("overcapture not flagged");
  update_load_a: assert property (
    eg_wr && i_wdata[EG_UPD] |=> o_count_load && o_prescaler_clear
      && o_count_load_value == ($past(i_count_down)
                                ? $past(i_auto_reload_value) : '0))
    else $error("update load value wrong");
  sel_lock_a: assert property (
    i_chan_on[0] |=> sel1 == $past(sel1))
    else $error("select changed while channel on");
  ext_clear_a: assert property (
    mode_q[CM_CLR] && i_external_trigger_filtered
    |-> !o_chan1_reference)
    else $error("reference not cleared");
  evgen_read_a: assert property (
    i_rd && i_addr == OFF_EVGEN |=> o_rdata == 16'h0000)
    else $error("generation register read not zero");
  preload_move_a: assert property (
    upd_ev && pre_on[0] && !is_in[0] && !ccv_wr[0]
    |=> ccv_act_q[0] == $past(ccv_shd_q[0]))
    else $error("preload not transferred");

endmodule // teg_event_gen
`default_nettype wire

/* File: verification/teg_pin_model.sv */
// pin side model: channel pins, internal trigger and external clear
// assumes the bench commands every edge through the tasks below
`timescale 1ns/1ps
`default_nettype none
module teg_pin_model (
  input wire logic i_mclk,
  output logic o_pin_one,
  output logic o_pin_two,
  output logic o_trig_int,
  output logic o_ext_clear
);
  // all sources idle low; the pins are always driven, never released
  initial begin
    o_pin_one = 1'b0;
    o_pin_two = 1'b0;
    o_trig_int = 1'b0;
    o_ext_clear = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // one rising edge, held three cycles so a slow sampler still sees it
  // idx 0 internal trigger, 1 pin one, 2 pin two
  task automatic pulse(input int idx);
    @(posedge i_mclk);
    if (idx == 0) o_trig_int <= 1'b1;
    if (idx == 1) o_pin_one <= 1'b1;
    if (idx == 2) o_pin_two <= 1'b1;
    repeat (3) @(posedge i_mclk);
    o_trig_int <= 1'b0;
    o_pin_one <= 1'b0;
    o_pin_two <= 1'b0;
  endtask

  // external clear level changes only just after an edge
  task automatic set_clear(input logic lvl);
    @(posedge i_mclk);
    o_ext_clear <= lvl;
  endtask
endmodule // teg_pin_model
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the timer event generator block
// assumes the design package and the pin model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import teg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, down = 1'b0, trigger_source_select = 1'b0;
  logic pol = 1'b0, npol = 1'b0;
  logic tick = 1'b0, uhw = 1'b0, thw = 1'b0; // counter core strobes
  logic ref2, m2, c2; // channel two outputs
  logic [15:0] cnt = 16'h0000, arr = 16'h0000; // counter side values
  logic [3:0] chon = 4'h0; // channel enables
  logic [1:0] c34 = 2'b00; // channels three and four stay outputs
  logic [6:0] ien = 7'h7f, den = 7'h7f;
  logic [15:0] rdata, ldv;
  logic p1, p2, internal_trigger_source, etr, upd, psc, ld, trg, irq, ref1, m1, c1;
  logic [3:0] chev;
  logic [6:0] dma;
  logic [15:0] seed = 16'h0055; // lfsr state
  logic rd_seen = 1'b0;
  logic [15:0] expq[$]; // expected read data, oldest first
  string nameq[$];
  int miscompares = 0;
  int checks_done = 0;

  always #5 i_mclk = ~i_mclk;

  ////////////////////////////////////////////////////////////////////
  teg_event_gen #(.CW(16)) u_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_count_value(cnt), .i_auto_reload_value(arr),
    .i_count_down(down), .i_count_tick(tick), .i_update_hw(uhw),
    .i_trigger_hw(thw), .i_chan_on(chon), .i_chan34_input(c34),
    .i_trigger_source_select_int(trigger_source_select), .i_pin_input_one(p1),
    .i_pin_input_two(p2), .i_pin_input_three(1'b0),
    .i_pin_input_four(1'b0), .i_internal_trigger_source(internal_trigger_source),
    .i_external_trigger_filtered(etr), .i_chan1_polarity(pol),
    .i_chan1_complement_polarity(npol), .i_chan2_polarity(pol),
    .i_chan2_complement_polarity(npol), .i_int_en(ien),
    .i_dma_en(den), .o_update_event(upd), .o_prescaler_clear(psc),
    .o_count_load(ld), .o_count_load_value(ldv),
    .o_trigger_event(trg), .o_chan_event(chev), .o_irq(irq),
    .o_dma_req(dma), .o_chan1_reference(ref1), .o_chan1_main_out(m1),
    .o_chan1_complement_out(c1), .o_chan2_reference(ref2),
    .o_chan2_main_out(m2), .o_chan2_complement_out(c2)
  );

  teg_pin_model u_pins (
    .i_mclk(i_mclk), .o_pin_one(p1), .o_pin_two(p2),
    .o_trig_int(internal_trigger_source), .o_ext_clear(etr)
  );

  ////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // case inequality so an unknown never passes
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask

  // read strobe; the expectation is queued for the monitor
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e,
                        input string n);
    @(posedge i_mclk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back(e);
    nameq.push_back(n);
    @(posedge i_mclk);
    rd <= 1'b0;
  endtask

  // monitor: read data stand from the cycle after the strobe until the next read
  always @(posedge i_mclk) begin
    if (rd_seen) chk(nameq.pop_front(), expq.pop_front(), rdata);
    rd_seen <= rd;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd_reg(OFF_CHMODE, RST_CHMODE, "mode reset");
    rd_reg(OFF_STATUS, RST_STATUS, "status reset");
    rd_reg(OFF_EVGEN, 16'h0000, "evgen read");
    rd_reg(8'h7c, 16'h0000, "unmapped read");
    $display("test reset done");
    // several generation bits at once, reserved bits kept zero
    wr_reg(OFF_EVGEN, 16'h0043);
    #1;
    chk("update pulse", 16'h0001, upd);
    chk("prescaler clear", 16'h0001, psc);
    chk("load value up", 16'h0000, ldv);
    chk("chan events", 16'h0001, chev);
    chk("trigger pulse", 16'h0001, trg);
    chk("dma requests", 16'h0043, dma);
    @(posedge i_mclk);
    #1;
    chk("pulse ends", 16'h0000, upd);
    chk("irq", 16'h0001, irq);
    rd_reg(OFF_STATUS, 16'h0043, "event flags");
    rd_reg(OFF_EVGEN, 16'h0000, "self clear");
    wr_reg(OFF_STATUS, 16'h0000);
    $display("test events done");
    // down counting update loads the reload value
    seed = lfsr(seed);
    arr <= seed;
    down <= 1'b1;
    wr_reg(OFF_EVGEN, 16'h0001);
    #1;
    chk("count load", 16'h0001, ld);
    chk("load value down", arr, ldv);
    down <= 1'b0;
    wr_reg(OFF_STATUS, 16'h0000);
    $display("test update done");
    // software capture twice on an input channel
    wr_reg(OFF_CHMODE, 16'h0001);
    seed = lfsr(seed);
    cnt <= seed;
    wr_reg(OFF_EVGEN, 16'h0002);
    seed = lfsr(seed);
    cnt <= seed;
    wr_reg(OFF_EVGEN, 16'h0002);
    rd_reg(OFF_STATUS, 16'h0202, "overcapture");
    rd_reg(OFF_CCV1, seed, "capture value");
    rd_reg(OFF_STATUS, 16'h0200, "flag after read");
    wr_reg(OFF_STATUS, 16'h0000);
    rd_reg(OFF_STATUS, 16'h0000, "overcapture cleared");
    $display("test capture done");
    // channel two input mapping: wrong source first, then right one
    for (int k = 1; k < 4; k++) begin
      wr_reg(OFF_STATUS, 16'h0000);
      trigger_source_select <= 1'b0;
      wr_reg(OFF_CHMODE, 16'(k) << 8);
      u_pins.pulse(k == 1 ? 1 : (k == 2 ? 2 : 0));
      rd_reg(OFF_STATUS, 16'h0000, "wrong source");
      trigger_source_select <= 1'b1;
      u_pins.pulse(k == 1 ? 2 : (k == 2 ? 1 : 0));
      rd_reg(OFF_STATUS, 16'h0004, "mapped source");
    end
    $display("test mapping done");
    // select field locked while the channel is on, mode still lands
    chon <= 4'h2;
    wr_reg(OFF_CHMODE, 16'h7100);
    rd_reg(OFF_CHMODE, 16'h7300, "locked select");
    chon <= 4'h0;
    $display("test lock done");
    // forced reference, polarity and external clear
    pol <= 1'b1;
    wr_reg(OFF_CHMODE, 16'h00d0);
    repeat (2) @(posedge i_mclk);
    #1;
    chk("ref forced high", 16'h0001, ref1);
    chk("main out", 16'h0000, m1);
    chk("comp out", 16'h0000, c1);
    chk("chan2 ref frozen", 16'h0000, ref2);
    chk("chan2 main out", 16'h0001, m2);
    chk("chan2 comp out", 16'h0001, c2);
    u_pins.set_clear(1'b1);
    #1;
    chk("ref cleared", 16'h0000, ref1);
    wr_reg(OFF_CHMODE, 16'h0050);
    repeat (2) @(posedge i_mclk);
    #1;
    chk("clear ignored", 16'h0001, ref1);
    u_pins.set_clear(1'b0);
    wr_reg(OFF_CHMODE, 16'h0040);
    repeat (2) @(posedge i_mclk);
    #1;
    chk("ref forced low", 16'h0000, ref1);
    $display("test reference done");
    // counter core strobes: match on tick, hardware trigger and update
    wr_reg(OFF_STATUS, 16'h0000);
    wr_reg(OFF_CCV1, 16'h0123);
    cnt <= 16'h0123;
    tick <= 1'b1;
    thw <= 1'b1;
    uhw <= 1'b1;
    @(posedge i_mclk);
    tick <= 1'b0;
    thw <= 1'b0;
    uhw <= 1'b0;
    rd_reg(OFF_STATUS, 16'h0043, "hardware flags");
    $display("test hardware done");
    repeat (3) @(posedge i_mclk);
    stop_test();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge i_mclk);
    miscompares++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
